// [core/rtc_timer_irq.sv]
// Functional notes
// [R1] Raw status: calendar bit0, countdown bit1
// [R2] Masked status: post-mask bits 0 and 1
// [R3] Clear bit0 write 1 clears calendar
// [R4] Clear bit1 write 1 clears countdown
// [R5] Read-only 32-bit counter, reset 0x0FFFFFFF
// [R6] Periodic: interrupt at zero, reload, continue
// [R7] Single-run: interrupt at zero, then halt
// [R8] Run bit acts on next tick of the selected clock
// [R9] Halted counter frozen; run bit readable
// [R10] Load write while halted sets run
// [R11] Single-run zero clears run bit
// [R12] Self-start: load/pattern write sets run
// [R13] Bits 10:4 give pattern length
// [R14] Bit 11 selects slow or trimmed clock
// [R15] Bit 12 bypasses internal clock gating
// [R16] Mask register enables bits 0 and 1
// [R17] 128-bit pattern over four words
// [R18] Masked bit is raw AND enable
// [R19] Raw bits sticky until software clears
module rtc_timer_irq
  import rtc_timer_pkg::*;
#(
  parameter int unsigned ADDR_W = rtc_timer_pkg::APB_ADDR_W, // APB address width
  parameter int unsigned LEN_W = 7 // Pattern length field width
) (
  input wire logic sys_clk_i, // System clock, 100 MHz
  input wire logic rstn_i, // Synchronous reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction, high for write
  input wire logic [ADDR_W-1:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error on unmapped address
  input wire logic slow_clock_i, // Raw 32 kHz clock pin
  input wire logic trimmed_clock_i, // Trimmed 32 kHz clock pin
  input wire logic calendar_irq_i, // Clockwatch event pulse, same clock
  output logic calendar_irq_o, // Masked clockwatch interrupt
  output logic countdown_irq_o, // Masked timer interrupt
  output logic clk_gate_open_o // Timer clock gate open
);

  import rtc_timer_pkg::*;

  // Elaboration checks
  if (ADDR_W < 7) begin : g_addr_check
    $error("ADDR_W too small for register map");
  end
  if (LEN_W != 7) begin : g_len_check
    $error("LEN_W must match the pattern pointer");
  end

  // Address match on the low twelve bits with any upper bits zero, aligned words only
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    logic [11:0] low;
    low = 12'(a);
    hit = (low == ofs) && (ADDR_W <= 12 || (a >> 12) == '0);
  endfunction

  // Any mapped register
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, OFS_IRQ_ENABLE_MASK) | hit(a, OFS_IRQ_RAW_STATUS)
           | hit(a, OFS_IRQ_MASKED_STATUS) | hit(a, OFS_IRQ_CLEAR)
           | hit(a, OFS_TIMER_VALUE) | hit(a, OFS_TIMER_CONTROL)
           | hit(a, OFS_RELOAD_FIRST) | hit(a, OFS_RELOAD_SECOND)
           | hit(a, OFS_PATTERN_0) | hit(a, OFS_PATTERN_1)
           | hit(a, OFS_PATTERN_2) | hit(a, OFS_PATTERN_3)
           | hit(a, OFS_EVENT_COUNT);
  endfunction

  // Bus state
  apb_state_t state_reg; // Answer machine state
  logic [31:0] prdata_reg; // Captured read data
  logic pready_reg; // Ready flop
  logic pslverr_reg; // Error flop

  // Register storage
  logic [1:0] mask_reg; // Interrupt enables
  logic [1:0] raw_reg; // Sticky raw flags
  logic [1:0] raw_next; // Raw flags next value
  logic [31:0] ctl_reg; // Timer control
  logic [31:0] count_reg; // Down counter
  logic [31:0] reload_reg [0:1]; // Two reload values
  logic [31:0] pattern_reg [0:PATTERN_WORDS-1]; // Pattern words
  logic [6:0] ptr_reg; // Pattern pointer
  logic [31:0] events_reg; // Timer event count
  logic cal_irq_reg; // Masked calendar output
  logic cnt_irq_reg; // Masked countdown output
  logic gate_reg; // Clock gate output

  // Decoded strobes
  logic commit; // Transfer completes this edge
  logic wr_en; // Write completes this edge
  logic wr_mask; // Mask register write
  logic wr_clear; // Clear register write
  logic wr_ctl; // Control register write
  logic wr_reload [0:1]; // Reload register writes
  logic wr_load_any; // Any reload write
  logic wr_pattern_any; // Any pattern write
  logic [PATTERN_WORDS-1:0] wr_pattern; // Per-word pattern writes

  // Timer helpers
  logic [1:0] tick_raw; // Synchronised edges: slow, trimmed
  logic tick; // Selected count tick
  logic running; // Run bit
  logic at_zero; // Counter reached zero
  logic timer_event; // Zero reached on a running tick
  logic [PATTERN_BITS-1:0] pattern_flat; // Whole pattern
  logic [6:0] len; // Useful pattern length
  logic [7:0] ptr_inc; // Pointer plus one
  logic [6:0] ptr_next; // Wrapped pointer

  // Transfer completes on the edge where ready is seen high
  assign commit = psel_i & penable_i & pready_reg;
  assign wr_en = commit & pwrite_i & ~pslverr_reg;
  assign wr_mask = wr_en & hit(paddr_i, OFS_IRQ_ENABLE_MASK);
  assign wr_clear = wr_en & hit(paddr_i, OFS_IRQ_CLEAR);
  assign wr_ctl = wr_en & hit(paddr_i, OFS_TIMER_CONTROL);
  assign wr_reload[0] = wr_en & hit(paddr_i, OFS_RELOAD_FIRST);
  assign wr_reload[1] = wr_en & hit(paddr_i, OFS_RELOAD_SECOND);
  assign wr_pattern[0] = wr_en & hit(paddr_i, OFS_PATTERN_0);
  assign wr_pattern[1] = wr_en & hit(paddr_i, OFS_PATTERN_1);
  assign wr_pattern[2] = wr_en & hit(paddr_i, OFS_PATTERN_2);
  assign wr_pattern[3] = wr_en & hit(paddr_i, OFS_PATTERN_3);
  assign wr_load_any = wr_reload[0] | wr_reload[1];
  assign wr_pattern_any = |wr_pattern;

  // Pin clocks pass the synchroniser before any use
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tick
      edge_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .pin_i(gi == 0 ? slow_clock_i : trimmed_clock_i),
        .rise_o(tick_raw[gi])
      );
    end
  endgenerate

  // [R14] Count clock select
  assign tick = ctl_reg[CTL_CLK_SEL] ? tick_raw[1] : tick_raw[0];

  assign running = ctl_reg[CTL_RUN];
  assign at_zero = (count_reg == RST_ZERO);
  // [R8] Run bit sampled per tick
  assign timer_event = tick & running & at_zero;

  // [R17] Pattern words, highest word on top
  assign pattern_flat = {pattern_reg[3], pattern_reg[2], pattern_reg[1], pattern_reg[0]};

  // [R13] Pointer wraps at the useful length
  assign len = ctl_reg[CTL_LEN_MSB:CTL_LEN_LSB];
  assign ptr_inc = {1'b0, ptr_reg} + 8'h01;
  assign ptr_next = (ptr_inc >= {1'b0, len}) ? RST_POINTER : ptr_inc[6:0];

  // [R19] Set wins over clear
  always_comb begin
    raw_next = raw_reg;
    // [R3] Calendar clear
    if (wr_clear && pwdata_i[BIT_CALENDAR]) begin
      raw_next[BIT_CALENDAR] = 1'b0;
    end
    // [R4] Countdown clear
    if (wr_clear && pwdata_i[BIT_COUNTDOWN]) begin
      raw_next[BIT_COUNTDOWN] = 1'b0;
    end
    // Events set the flags
    if (calendar_irq_i) begin
      raw_next[BIT_CALENDAR] = 1'b1;
    end
    if (timer_event) begin
      raw_next[BIT_COUNTDOWN] = 1'b1;
    end
  end

  // APB answer machine: one wait cycle, then ready
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state_reg <= APB_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      case (state_reg)
        APB_IDLE: begin
          // Access phase seen, answer next edge
          if (psel_i && penable_i) begin
            state_reg <= APB_ANSWER;
            pready_reg <= 1'b1;
            pslverr_reg <= ~mapped(paddr_i);
          end
        end
        APB_ANSWER: begin
          // Ready lasts one cycle
          state_reg <= APB_IDLE;
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
        end
        default: begin
          state_reg <= APB_IDLE;
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
        end
      endcase
    end
  end

  // Read data captured as the answer is raised
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      prdata_reg <= RST_ZERO;
    end else if (state_reg == APB_IDLE && psel_i && penable_i && !pwrite_i) begin
      prdata_reg <= RST_ZERO;
      // [R16] Enable bits readable
      if (hit(paddr_i, OFS_IRQ_ENABLE_MASK)) begin
        prdata_reg[1:0] <= mask_reg;
      end
      // [R1] Raw flags
      if (hit(paddr_i, OFS_IRQ_RAW_STATUS)) begin
        prdata_reg[1:0] <= raw_reg;
      end
      // [R2] [R18] Masked flags
      if (hit(paddr_i, OFS_IRQ_MASKED_STATUS)) begin
        prdata_reg[1:0] <= raw_reg & mask_reg;
      end
      // [R5] Counter value
      if (hit(paddr_i, OFS_TIMER_VALUE)) begin
        prdata_reg <= count_reg;
      end
      // [R9] Control incl. live run bit
      if (hit(paddr_i, OFS_TIMER_CONTROL)) begin
        prdata_reg <= ctl_reg;
      end
      if (hit(paddr_i, OFS_RELOAD_FIRST)) begin
        prdata_reg <= reload_reg[0];
      end
      if (hit(paddr_i, OFS_RELOAD_SECOND)) begin
        prdata_reg <= reload_reg[1];
      end
      if (hit(paddr_i, OFS_PATTERN_0)) begin
        prdata_reg <= pattern_reg[0];
      end
      if (hit(paddr_i, OFS_PATTERN_1)) begin
        prdata_reg <= pattern_reg[1];
      end
      if (hit(paddr_i, OFS_PATTERN_2)) begin
        prdata_reg <= pattern_reg[2];
      end
      if (hit(paddr_i, OFS_PATTERN_3)) begin
        prdata_reg <= pattern_reg[3];
      end
      if (hit(paddr_i, OFS_EVENT_COUNT)) begin
        prdata_reg <= events_reg;
      end
    end
  end

  // [R16] Mask register
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      mask_reg <= RST_IRQ_BITS;
    end else if (wr_mask) begin
      mask_reg <= pwdata_i[1:0];
    end
  end

  // [R19] Sticky raw flags
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      raw_reg <= RST_IRQ_BITS;
    end else begin
      raw_reg <= raw_next;
    end
  end

  // [R18] Masked outputs follow raw and enables
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      cal_irq_reg <= 1'b0;
      cnt_irq_reg <= 1'b0;
    end else begin
      cal_irq_reg <= raw_next[BIT_CALENDAR] & mask_reg[BIT_CALENDAR];
      cnt_irq_reg <= raw_next[BIT_COUNTDOWN] & mask_reg[BIT_COUNTDOWN];
    end
  end

  // Control register with hardware run-bit updates
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ctl_reg <= RST_ZERO;
    end else if (wr_ctl) begin
      // Software write wins over hardware updates
      ctl_reg <= pwdata_i & CTL_WRITE_MASK;
    end else if (timer_event && ctl_reg[CTL_SINGLE_RUN]) begin
      // [R11] Single-run stop at zero
      ctl_reg[CTL_RUN] <= 1'b0;
    end else if (wr_load_any && !running) begin
      // [R10] Load while halted starts
      ctl_reg[CTL_RUN] <= 1'b1;
    end else if ((wr_load_any || wr_pattern_any) && ctl_reg[CTL_SELF_START]) begin
      // [R12] Self-start on load or pattern
      ctl_reg[CTL_RUN] <= 1'b1;
    end
  end

  // [R15] Gate open while running or bypassed
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      gate_reg <= 1'b0;
    end else begin
      gate_reg <= ctl_reg[CTL_GATE_OVR] | running;
    end
  end

  // Reload values
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      reload_reg[0] <= RST_ZERO;
      reload_reg[1] <= RST_ZERO;
    end else begin
      if (wr_reload[0]) begin
        reload_reg[0] <= pwdata_i;
      end
      if (wr_reload[1]) begin
        reload_reg[1] <= pwdata_i;
      end
    end
  end

  // [R17] Pattern words
  generate
    for (gi = 0; gi < PATTERN_WORDS; gi++) begin : g_pattern
      always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
          pattern_reg[gi] <= RST_ZERO;
        end else if (wr_pattern[gi]) begin
          pattern_reg[gi] <= pwdata_i;
        end
      end
    end
  endgenerate

  // Down counter and pattern pointer
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      // [R5] Counter reset value
      count_reg <= RST_TIMER_VALUE;
      ptr_reg <= RST_POINTER;
    end else if (wr_reload[0] && !running) begin
      // Halted load presets counter from first value
      count_reg <= pwdata_i;
      ptr_reg <= RST_POINTER;
    end else if (tick && running) begin
      if (at_zero) begin
        // [R6] Periodic reload via pattern bit
        if (!ctl_reg[CTL_SINGLE_RUN]) begin
          count_reg <= reload_reg[pattern_flat[ptr_reg]];
          ptr_reg <= ptr_next;
        end
        // [R7] Single-run holds at zero
      end else begin
        count_reg <= count_reg - 32'h0000_0001;
      end
    end
    // [R9] No tick or halted: frozen
  end

  // Timer event counter
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      events_reg <= RST_ZERO;
    end else if (timer_event) begin
      events_reg <= events_reg + 32'h0000_0001;
    end
  end

  // Outputs straight from flops
  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign calendar_irq_o = cal_irq_reg;
  assign countdown_irq_o = cnt_irq_reg;
  assign clk_gate_open_o = gate_reg;

endmodule

// [core/rtc_timer_pkg.sv]
package rtc_timer_pkg;

  // Bus geometry
  localparam int unsigned APB_ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [11:0] OFS_IRQ_ENABLE_MASK = 12'h01c;
  localparam logic [11:0] OFS_IRQ_RAW_STATUS = 12'h020;
  localparam logic [11:0] OFS_IRQ_MASKED_STATUS = 12'h024;
  localparam logic [11:0] OFS_IRQ_CLEAR = 12'h028;
  localparam logic [11:0] OFS_TIMER_VALUE = 12'h02c;
  localparam logic [11:0] OFS_TIMER_CONTROL = 12'h030;
  localparam logic [11:0] OFS_RELOAD_FIRST = 12'h034;
  localparam logic [11:0] OFS_RELOAD_SECOND = 12'h038;
  localparam logic [11:0] OFS_PATTERN_0 = 12'h03c;
  localparam logic [11:0] OFS_PATTERN_1 = 12'h040;
  localparam logic [11:0] OFS_PATTERN_2 = 12'h044;
  localparam logic [11:0] OFS_PATTERN_3 = 12'h048;
  localparam logic [11:0] OFS_EVENT_COUNT = 12'h04c;

  // Interrupt bit positions
  localparam int unsigned BIT_CALENDAR = 0;
  localparam int unsigned BIT_COUNTDOWN = 1;

  // Timer control field positions
  localparam int unsigned CTL_SINGLE_RUN = 0;
  localparam int unsigned CTL_RUN = 1;
  localparam int unsigned CTL_SELF_START = 2;
  localparam int unsigned CTL_LEN_LSB = 4;
  localparam int unsigned CTL_LEN_MSB = 10;
  localparam int unsigned CTL_CLK_SEL = 11;
  localparam int unsigned CTL_GATE_OVR = 12;

  // Writable control bits, reserved bits stay zero
  localparam logic [31:0] CTL_WRITE_MASK = 32'h0000_1ff7;

  // Reset values
  localparam logic [31:0] RST_TIMER_VALUE = 32'h0fff_ffff;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [1:0] RST_IRQ_BITS = 2'h0;
  localparam logic [6:0] RST_POINTER = 7'h00;

  // Pattern geometry
  localparam int unsigned PATTERN_WORDS = 4;
  localparam int unsigned PATTERN_BITS = 128;

  // Bus answer machine
  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_ANSWER = 2'b10
  } apb_state_t;

endpackage

// [core/edge_sync.sv]
// Two-flop synchroniser with registered rising-edge pulse
module edge_sync (
  input wire logic sys_clk_i, // System clock
  input wire logic rstn_i, // Synchronous reset, active low
  input wire logic pin_i, // Asynchronous clock or level
  output logic rise_o // One-cycle pulse per rising edge
);

  logic meta_reg; // First stage, read only by second
  logic sync_reg; // Second stage
  logic hist_reg; // Previous synchronised level
  logic rise_reg; // Registered edge pulse

  // Synchroniser chain and edge detect
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      hist_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      hist_reg <= sync_reg;
      rise_reg <= sync_reg & ~hist_reg;
    end
  end

  assign rise_o = rise_reg;

endmodule

// [bench/rtc_timer_irq_asserts.sv]
module rtc_timer_irq_asserts
  import rtc_timer_pkg::*;
#(
  parameter int unsigned ADDR_W = rtc_timer_pkg::APB_ADDR_W // Address width
) (
  input wire logic sys_clk_i, // System clock
  input wire logic rstn_i, // Reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic [ADDR_W-1:0] paddr_i, // APB address
  input wire logic [31:0] pwdata_i, // APB write data
  input wire logic [31:0] prdata_o, // APB read data
  input wire logic pready_o, // APB ready
  input wire logic pslverr_o, // APB error
  input wire logic slow_clock_i, // Raw slow clock
  input wire logic trimmed_clock_i, // Trimmed clock
  input wire logic calendar_irq_i, // Calendar event
  input wire logic calendar_irq_o, // Masked calendar irq
  input wire logic countdown_irq_o, // Masked timer irq
  input wire logic clk_gate_open_o // Gate open
);
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_timer_pkg::*;
  logic wr_done; // Write commit edge
  logic mask_wr; // Mask write commit
  logic clr_wr; // Clear write commit
  logic ctl_wr; // Control write commit
  logic [1:0] mask_sh; // Shadow of enable mask
  assign wr_done = psel_i && penable_i && pready_o && pwrite_i;
  assign mask_wr = wr_done && (paddr_i == ADDR_W'(OFS_IRQ_ENABLE_MASK));
  assign clr_wr = wr_done && (paddr_i == ADDR_W'(OFS_IRQ_CLEAR));
  assign ctl_wr = wr_done && (paddr_i == ADDR_W'(OFS_TIMER_CONTROL));
  // Follow mask writes
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      mask_sh <= 2'h0;
    end else if (mask_wr) begin
      mask_sh <= pwdata_i[1:0];
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // Output low once register and output stage settle
  sequence s_low_later(sig);
    ##2 !sig;
  endsequence
  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  property p_err_ready;
    pslverr_o |-> pready_o;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_cal_set;
    calendar_irq_i && mask_sh[0] && !mask_wr |=> calendar_irq_o;
  endproperty
  a_cal_set: assert property (p_cal_set) else $error("calendar irq missing");
  property p_cal_masked;
    !$past(mask_sh[0]) |-> !calendar_irq_o;
  endproperty
  a_cal_masked: assert property (p_cal_masked) else $error("calendar irq unmasked");
  property p_cd_masked;
    mask_wr && !pwdata_i[1] |-> s_low_later(countdown_irq_o);
  endproperty
  a_cd_masked: assert property (p_cd_masked) else $error("timer irq unmasked");
  property p_cal_clear;
    clr_wr && pwdata_i[0] && !calendar_irq_i |=> !calendar_irq_o;
  endproperty
  a_cal_clear: assert property (p_cal_clear) else $error("calendar clear ignored");
  property p_cd_clear;
    // Pin low two cycles back; a tick at the clear edge comes from the pin level three cycles back
    clr_wr && pwdata_i[1] && !$past(slow_clock_i, 2) && !$past(trimmed_clock_i, 2)
      |=> !countdown_irq_o;
  endproperty
  a_cd_clear: assert property (p_cd_clear) else $error("timer clear ignored");
  property p_cal_sticky;
    calendar_irq_o && !mask_wr && !(clr_wr && pwdata_i[0]) |=> calendar_irq_o;
  endproperty
  a_cal_sticky: assert property (p_cal_sticky) else $error("calendar irq dropped");
  property p_gate_bypass;
    ctl_wr && pwdata_i[12] |-> ##2 clk_gate_open_o;
  endproperty
  a_gate_bypass: assert property (p_gate_bypass) else $error("gate not open");
endmodule

bind rtc_timer_irq rtc_timer_irq_asserts #(.ADDR_W(ADDR_W)) u_rtc_timer_irq_asserts (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .slow_clock_i(slow_clock_i),
  .trimmed_clock_i(trimmed_clock_i), .calendar_irq_i(calendar_irq_i),
  .calendar_irq_o(calendar_irq_o), .countdown_irq_o(countdown_irq_o),
  .clk_gate_open_o(clk_gate_open_o)
);

// [bench/rtc_timer_irq_test.sv]
module rtc_timer_irq_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_timer_pkg::*;
  logic sys_clk_i, rstn_i, psel_i, penable_i, pwrite_i;
  logic slow_clock_i, trimmed_clock_i, calendar_irq_i;
  logic [11:0] paddr_i; // Bus address
  logic [31:0] pwdata_i, prdata_o;
  logic pready_o, pslverr_o, calendar_irq_o, countdown_irq_o, clk_gate_open_o;
  logic [31:0] rd_val; // Last read data
  logic rd_err; // Last error flag
  int n_fail = 0;
  int total_checks = 0;
  // Clock, 10 ns period
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  rtc_timer_irq u_rtc_timer_irq (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .slow_clock_i(slow_clock_i),
    .trimmed_clock_i(trimmed_clock_i), .calendar_irq_i(calendar_irq_i),
    .calendar_irq_o(calendar_irq_o), .countdown_irq_o(countdown_irq_o),
    .clk_gate_open_o(clk_gate_open_o)
  );
  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer, held until ready
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= addr;
    pwdata_i <= data;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge sys_clk_i);
    end while (pready_o !== 1'b1);
    rd_val = prdata_o;
    rd_err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] addr, input logic [31:0] data);
    apb(1'b1, addr, data);
  endtask
  task automatic rd(input logic [11:0] addr, input logic [31:0] exp, input string name);
    apb(1'b0, addr, 32'h0000_0000);
    check(name, rd_val, exp);
  endtask
  // One rising edge on a timer clock pin, then settle
  task automatic tick(input logic trim);
    @(posedge sys_clk_i);
    if (trim) begin
      trimmed_clock_i <= 1'b1;
    end else begin
      slow_clock_i <= 1'b1;
    end
    repeat (4) @(posedge sys_clk_i);
    trimmed_clock_i <= 1'b0;
    slow_clock_i <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
  endtask
  // Final verdict and stop
  task automatic give_verdict();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog against hangs
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_fail++;
    give_verdict();
  end
  // Main sequence
  initial begin
    rstn_i = 1'b0;
    {psel_i, penable_i, pwrite_i, slow_clock_i, trimmed_clock_i, calendar_irq_i} = 6'h00;
    paddr_i = 12'h000;
    pwdata_i = 32'h0000_0000;
    repeat (5) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    rd(OFS_IRQ_ENABLE_MASK, 32'h0000_0000, "mask");
    rd(OFS_IRQ_RAW_STATUS, 32'h0000_0000, "raw");
    rd(OFS_IRQ_MASKED_STATUS, 32'h0000_0000, "masked");
    rd(OFS_TIMER_VALUE, 32'h0fff_ffff, "value");
    apb(1'b0, 12'h000, 32'h0000_0000);
    check("unmapped", {31'h0, rd_err}, 32'h0000_0001);
    wr(OFS_TIMER_VALUE, 32'h0000_0000);
    rd(OFS_TIMER_VALUE, 32'h0fff_ffff, "value_ro");
    // Calendar event, masked, enabled, cleared
    @(posedge sys_clk_i);
    calendar_irq_i <= 1'b1;
    @(posedge sys_clk_i);
    calendar_irq_i <= 1'b0;
    rd(OFS_IRQ_RAW_STATUS, 32'h0000_0001, "raw_cal");
    rd(OFS_IRQ_MASKED_STATUS, 32'h0000_0000, "mis_off");
    wr(OFS_IRQ_ENABLE_MASK, 32'h0000_0003);
    rd(OFS_IRQ_ENABLE_MASK, 32'h0000_0003, "mask_rw");
    rd(OFS_IRQ_MASKED_STATUS, 32'h0000_0001, "mis_on");
    wr(OFS_IRQ_CLEAR, 32'h0000_0002);
    rd(OFS_IRQ_RAW_STATUS, 32'h0000_0001, "cal_keep");
    wr(OFS_IRQ_CLEAR, 32'h0000_0001);
    rd(OFS_IRQ_RAW_STATUS, 32'h0000_0000, "cal_clr");
    rd(OFS_IRQ_CLEAR, 32'h0000_0000, "clr_rd");
    // Calendar event with the enable set drives the output
    @(posedge sys_clk_i);
    calendar_irq_i <= 1'b1;
    @(posedge sys_clk_i);
    calendar_irq_i <= 1'b0;
    @(posedge sys_clk_i);
    check("cal_irq_on", {31'h0, calendar_irq_o}, 32'h0000_0001);
    wr(OFS_IRQ_CLEAR, 32'h0000_0001);
    rd(OFS_IRQ_RAW_STATUS, 32'h0000_0000, "cal_clr2");
    check("cal_irq_off", {31'h0, calendar_irq_o}, 32'h0000_0000);
    // Periodic countdown from a halted load
    wr(OFS_RELOAD_FIRST, 32'h0000_0002);
    rd(OFS_TIMER_CONTROL, 32'h0000_0002, "run_set");
    rd(OFS_TIMER_VALUE, 32'h0000_0002, "loaded");
    tick(1'b0);
    tick(1'b0);
    rd(OFS_IRQ_RAW_STATUS, 32'h0000_0000, "no_evt");
    tick(1'b0);
    rd(OFS_TIMER_VALUE, 32'h0000_0002, "reload");
    rd(OFS_IRQ_MASKED_STATUS, 32'h0000_0002, "mis_cd");
    check("cd_irq_on", {31'h0, countdown_irq_o}, 32'h0000_0001);
    wr(OFS_IRQ_CLEAR, 32'h0000_0001);
    rd(OFS_IRQ_RAW_STATUS, 32'h0000_0002, "cd_keep");
    wr(OFS_IRQ_CLEAR, 32'h0000_0002);
    rd(OFS_IRQ_RAW_STATUS, 32'h0000_0000, "cd_clr");
    check("cd_irq_clr", {31'h0, countdown_irq_o}, 32'h0000_0000);
    // Stop, restart, clock selection
    wr(OFS_TIMER_CONTROL, 32'h0000_0000);
    tick(1'b0);
    rd(OFS_TIMER_VALUE, 32'h0000_0002, "frozen");
    wr(OFS_TIMER_CONTROL, 32'h0000_0802);
    tick(1'b0);
    rd(OFS_TIMER_VALUE, 32'h0000_0002, "slow_off");
    tick(1'b1);
    rd(OFS_TIMER_VALUE, 32'h0000_0001, "trim_on");
    // Single run stops at zero
    wr(OFS_TIMER_CONTROL, 32'h0000_0001);
    wr(OFS_RELOAD_FIRST, 32'h0000_0001);
    rd(OFS_TIMER_CONTROL, 32'h0000_0003, "os_run");
    tick(1'b0);
    tick(1'b0);
    rd(OFS_TIMER_CONTROL, 32'h0000_0001, "os_halt");
    rd(OFS_IRQ_RAW_STATUS, 32'h0000_0002, "os_evt");
    tick(1'b0);
    rd(OFS_TIMER_VALUE, 32'h0000_0000, "os_hold");
    // Dropping the timer enable hides the pending flag
    wr(OFS_IRQ_ENABLE_MASK, 32'h0000_0001);
    rd(OFS_IRQ_MASKED_STATUS, 32'h0000_0000, "mis_cd_off");
    check("cd_irq_mask", {31'h0, countdown_irq_o}, 32'h0000_0000);
    wr(OFS_IRQ_ENABLE_MASK, 32'h0000_0003);
    wr(OFS_IRQ_CLEAR, 32'h0000_0003);
    // Two-entry pattern selects both reloads
    wr(OFS_TIMER_CONTROL, 32'h0000_0020);
    wr(OFS_PATTERN_0, 32'h0000_0002);
    wr(OFS_RELOAD_SECOND, 32'h0000_0003);
    rd(OFS_TIMER_CONTROL, 32'h0000_0022, "run_2nd");
    wr(OFS_TIMER_CONTROL, 32'h0000_0020);
    wr(OFS_RELOAD_FIRST, 32'h0000_0001);
    tick(1'b0);
    tick(1'b0);
    rd(OFS_TIMER_VALUE, 32'h0000_0001, "pat_bit0");
    tick(1'b0);
    tick(1'b0);
    rd(OFS_TIMER_VALUE, 32'h0000_0003, "pat_bit1");
    // Self start on a pattern write
    wr(OFS_TIMER_CONTROL, 32'h0000_0004);
    wr(OFS_PATTERN_3, 32'ha5a5_0f0f);
    rd(OFS_PATTERN_3, 32'ha5a5_0f0f, "pat_top");
    rd(OFS_TIMER_CONTROL, 32'h0000_0006, "self_run");
    // Field storage, bypass and reserved bits
    wr(OFS_TIMER_CONTROL, 32'h0000_1ff0);
    rd(OFS_TIMER_CONTROL, 32'h0000_1ff0, "fields");
    check("gate_byp", {31'h0, clk_gate_open_o}, 32'h0000_0001);
    wr(OFS_TIMER_CONTROL, 32'hffff_e008);
    rd(OFS_TIMER_CONTROL, 32'h0000_0000, "reserved");
    check("gate_shut", {31'h0, clk_gate_open_o}, 32'h0000_0000);
    give_verdict();
  end
endmodule
